// *** dsac_checker.sv ***
// Data-space access, alignment and stack checking for the core.
`timescale 1ns/10ps
`default_nettype none
module dsac_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Operating mode: dual-operand multiply-class instruction executing.
    input wire logic dualOperandMultiplyClass,
    // X access request.
    input wire logic xReqValid,
    input wire logic xReqWrite,
    input wire logic xReqByte,
    input wire logic xReqViaXPtr,
    input wire logic [dsac_pkg::DSAC_AW-1:0] xReqAddr,
    input wire logic [dsac_pkg::DSAC_DW-1:0] xWrData,
    input wire logic [dsac_pkg::DSAC_DW-1:0] xWregPrev,
    // X read answer.
    output logic xRdValid_q,
    output logic [dsac_pkg::DSAC_DW-1:0] xRdData_q,
    output logic [dsac_pkg::DSAC_DW-1:0] xWregData_q,
    // Y prefetch request and answer.
    input wire logic yReqValid,
    input wire logic [dsac_pkg::DSAC_AW-1:0] yReqAddr,
    output logic yRdValid_q,
    output logic [dsac_pkg::DSAC_DW-1:0] yRdData_q,
    // Pointer update.
    input wire logic [dsac_pkg::DSAC_AW-1:0] ptrIn,
    input wire logic ptrInc,
    input wire logic ptrDec,
    input wire logic ptrByte,
    output logic [dsac_pkg::DSAC_AW-1:0] ptrNext_q,
    // Direct address formation.
    input wire logic [dsac_pkg::DSAC_AW-1:0] dirField,
    input wire logic dirFullField,
    output logic [dsac_pkg::DSAC_AW-1:0] dirAddr_q,
    // Stack operations.
    input wire logic stackPush,
    input wire logic stackPop,
    input wire logic pushIsCall,
    input wire logic pushIsException,
    input wire logic [dsac_pkg::DSAC_DW-1:0] pushData,
    input wire logic [7:0] statusLowByte,
    input wire logic spWrite,
    input wire logic [dsac_pkg::DSAC_AW-1:0] spWrData,
    input wire logic limWrite,
    input wire logic [dsac_pkg::DSAC_AW-1:0] limWrData,
    output logic [dsac_pkg::DSAC_AW-1:0] stackPointerReg,
    output logic [dsac_pkg::DSAC_AW-1:0] stackLimitReg,
    // Trap requests to the exception logic.
    input wire logic addrErrAck,
    input wire logic stackErrAck,
    output logic addrErrReq,
    output logic stackErrReq
);
    import dsac_pkg::*;

    logic [15:0] spQ;
    logic [15:0] limQ;
    logic addrErrQ;
    logic stackErrQ;
    logic [15:0] rdAddr;
    logic [15:0] stackEa;
    logic [15:0] yAlign;
    logic [15:0] pushWord;
    logic [15:0] wrAddr;
    logic [DSAC_IDX_W-1:0] wrIdx;
    logic [DSAC_IDX_W-1:0] rdIdx;
    logic [DSAC_IDX_W-1:0] yIdx;
    logic [7:0] loWrByte;
    logic [7:0] hiWrByte;
    logic [7:0] loRdA;
    logic [7:0] hiRdA;
    logic [7:0] loRdB;
    logic [7:0] hiRdB;
    logic [7:0] selByte;
    logic [15:0] rdWord;
    logic misalign;
    logic memWrEn;
    logic loWe;
    logic hiWe;
    logic rdByte;
    logic rdZero;
    logic rdTake;
    logic stackErrEvent;

    // True where a byte address falls inside implemented memory.
    function automatic logic inRam(input logic [15:0] a);
        inRam = (a >= DSAC_RAM_BASE) && (a <= DSAC_RAM_TOP);
    endfunction

    // True where a byte address falls inside the fixed Y window.
    function automatic logic inY(input logic [15:0] a);
        inY = (a >= DSAC_Y_BASE) && (a <= DSAC_Y_TOP);
    endfunction

    // Word index of an address inside implemented memory.
    function automatic logic [DSAC_IDX_W-1:0] wordIdx(input logic [15:0] a);
        logic [15:0] off;
        off = a - DSAC_RAM_BASE;
        wordIdx = off[DSAC_IDX_W:1];
    endfunction

    // Stack addresses: pushes use the pointer, pops the word below it.
    assign stackEa = stackPush ? spQ : spQ - DSAC_WORD_STEP;

    // Odd address on a word access from the X side.
    assign misalign = xReqValid && !xReqByte && xReqAddr[0];

    // Pushed counter word: calls clear the top byte, exceptions add status.
    always_comb begin
        pushWord = pushData;
        if (pushIsException) begin
            pushWord = {statusLowByte, pushData[7:0]};
        end else if (pushIsCall) begin
            pushWord = {DSAC_ZERO_BYTE, pushData[7:0]};
        end
    end

    // Write path: the stack push owns the X write bus when both ask.
    assign wrAddr = stackPush ? spQ : xReqAddr;
    assign wrIdx = wordIdx(wrAddr);
    assign memWrEn = stackPush ? inRam(spQ)
        : (xReqValid && xReqWrite && !misalign && inRam(xReqAddr));
    assign loWe = memWrEn && (stackPush || !xReqByte || !xReqAddr[0]);
    assign hiWe = memWrEn && (stackPush || !xReqByte || xReqAddr[0]);
    assign loWrByte = stackPush ? pushWord[7:0] : xWrData[7:0];
    assign hiWrByte = stackPush ? pushWord[15:8]
        : (xReqByte ? xWrData[7:0] : xWrData[15:8]);

    // Read path: a pop reads the word below the pointer over the X bus.
    assign rdTake = stackPop || (xReqValid && !xReqWrite);
    assign rdAddr = stackPop ? stackEa : xReqAddr;
    assign rdIdx = wordIdx(rdAddr);
    assign rdByte = !stackPop && xReqByte;
    assign yAlign = {yReqAddr[15:1], 1'b0};
    assign yIdx = wordIdx(yAlign);

    // A read is zeroed when it misses memory or is an X-pointer fetch from Y space in a dual-operand multiply-class instruction.
    assign rdZero = !inRam(rdAddr)
        || (!stackPop && dualOperandMultiplyClass && xReqViaXPtr
            && inY(rdAddr));

    // Low and high lanes share one word decode.
    dsac_byte_lane uLaneLo (
        .clk_sys(clk_sys),
        .wrEn(loWe),
        .wrIdx(wrIdx),
        .wrByte(loWrByte),
        .rdIdxA(rdIdx),
        .rdByteA(loRdA),
        .rdIdxB(yIdx),
        .rdByteB(loRdB)
    );
    dsac_byte_lane uLaneHi (
        .clk_sys(clk_sys),
        .wrEn(hiWe),
        .wrIdx(wrIdx),
        .wrByte(hiWrByte),
        .rdIdxA(rdIdx),
        .rdByteA(hiRdA),
        .rdIdxB(yIdx),
        .rdByteB(hiRdB)
    );

    // Word and byte views of the X fetch.
    assign rdWord = {hiRdA, loRdA};
    assign selByte = rdZero ? DSAC_ZERO_BYTE
        : (rdAddr[0] ? hiRdA : loRdA);

    // X read answer, one cycle after the request.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xRdValid_q <= 1'b0;
            xRdData_q <= DSAC_ZERO_WORD;
            xWregData_q <= DSAC_ZERO_WORD;
        end else begin
            xRdValid_q <= rdTake;
            if (rdTake) begin
                if (rdByte) begin
                    xRdData_q <= {DSAC_ZERO_BYTE, selByte};
                    xWregData_q <= {xWregPrev[15:8], selByte};
                end else begin
                    // A misaligned word read still completes, aligned down.
                    xRdData_q <= rdZero ? DSAC_ZERO_WORD : rdWord;
                    xWregData_q <= rdZero ? DSAC_ZERO_WORD : rdWord;
                end
            end
        end
    end

    // Y prefetch answer; anything outside the Y window reads as zero.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            yRdValid_q <= 1'b0;
            yRdData_q <= DSAC_ZERO_WORD;
        end else begin
            yRdValid_q <= yReqValid;
            if (yReqValid) begin
                yRdData_q <= inY(yAlign) ? {hiRdB, loRdB}
                    : DSAC_ZERO_WORD;
            end
        end
    end

    // Pointer post-modify, scaled by operand size.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptrNext_q <= DSAC_ZERO_WORD;
        end else if (ptrInc) begin
            ptrNext_q <= ptrIn + (ptrByte ? DSAC_BYTE_STEP
                : DSAC_WORD_STEP);
        end else if (ptrDec) begin
            ptrNext_q <= ptrIn - (ptrByte ? DSAC_BYTE_STEP
                : DSAC_WORD_STEP);
        end else begin
            ptrNext_q <= ptrIn;
        end
    end

    // Direct address: the short field only reaches the near region.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dirAddr_q <= DSAC_ZERO_WORD;
        end else if (dirFullField) begin
            dirAddr_q <= dirField;
        end else begin
            dirAddr_q <= dirField & DSAC_NEAR_TOP;
        end
    end

    // Stack pointer; bit zero is kept clear on software writes.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spQ <= DSAC_SP_RESET;
        end else if (stackPush) begin
            spQ <= spQ + DSAC_WORD_STEP;
        end else if (stackPop) begin
            spQ <= spQ - DSAC_WORD_STEP;
        end else if (spWrite) begin
            spQ <= {spWrData[15:1], 1'b0};
        end
    end

    // Stack limit; the reset value stands in for an uninitialised limit.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            limQ <= DSAC_LIM_RESET;
        end else if (limWrite) begin
            limQ <= {limWrData[15:1], 1'b0};
        end
    end

    // Overflow only once the pointer has already passed the limit.
    assign stackErrEvent = (stackPush && (spQ > limQ))
        || ((stackPush || stackPop) && (stackEa < DSAC_SFR_BOUND));

    // Trap requests hold until accepted; a new event beats the accept.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addrErrQ <= 1'b0;
        end else if (misalign) begin
            addrErrQ <= 1'b1;
        end else if (addrErrAck) begin
            addrErrQ <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stackErrQ <= 1'b0;
        end else if (stackErrEvent) begin
            stackErrQ <= 1'b1;
        end else if (stackErrAck) begin
            stackErrQ <= 1'b0;
        end
    end

    assign addrErrReq = addrErrQ;
    assign stackErrReq = stackErrQ;
    assign stackPointerReg = spQ;
    assign stackLimitReg = limQ;

    // Checks on the behaviour above.
    // The next push may follow at once or after one quiet cycle.
    sequence s_push_at_limit;
        stackPush && !stackPop && !limWrite && (spQ == limQ)
        ##1 (stackPush or (!stackPush && !stackPop && !spWrite
            && !limWrite ##1 stackPush));
    endsequence

    sequence s_odd_word;
        xReqValid && !xReqByte && xReqAddr[0];
    endsequence

    a_unimpl_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        rdTake && !inRam(rdAddr) |=> xRdData_q == DSAC_ZERO_WORD)
        else $error("unimplemented fetch not zero");

    a_xptr_ywin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        xReqValid && !xReqWrite && !stackPop && dualOperandMultiplyClass
        && xReqViaXPtr && inY(xReqAddr) |=> xRdData_q == DSAC_ZERO_WORD)
        else $error("X pointer fetch from Y space not zero");

    a_yptr_xwin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        yReqValid && !inY(yAlign)
        |=> yRdValid_q && yRdData_q == DSAC_ZERO_WORD)
        else $error("Y pointer fetch outside Y space not zero");

    a_byte_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rdTake && rdByte |=> xRdData_q[15:8] == DSAC_ZERO_BYTE
        && xWregData_q[15:8] == $past(xWregPrev[15:8]))
        else $error("byte read upper byte wrong");

    a_ptr_scale: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ptrInc |=> ptrNext_q == $past(ptrIn) + ($past(ptrByte) ? 16'h0001
        : 16'h0002))
        else $error("pointer step not scaled");

    a_odd_trap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_odd_word |=> addrErrReq)
        else $error("misaligned word access did not trap");

    a_odd_nowrite: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        s_odd_word and (xReqWrite && !stackPush) |-> !loWe && !hiWe)
        else $error("misaligned write reached memory");

    a_near_field: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        !dirFullField |=> dirAddr_q <= DSAC_NEAR_TOP)
        else $error("short direct address left near region");

    a_push_step: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        stackPush ##1 !$past(spWrite) |-> spQ == $past(spQ) + 16'h0002)
        else $error("push did not advance stack pointer by a word");

    a_limit_even: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        limWrite |=> !limQ[0] && limQ[15:1] == $past(limWrData[15:1]))
        else $error("stack limit bit zero not clear");

    a_limit_over: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        s_push_at_limit |=> stackErrReq)
        else $error("push beyond limit did not trap");

    // A pop from address zero wraps to the top and is not an underflow.
    a_sfr_under: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        stackPop && !stackPush && spQ < 16'h0802 && spQ > 16'h0001
        |=> stackErrReq)
        else $error("stack underflow did not trap");

    a_trap_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        addrErrReq && !addrErrAck |=> addrErrReq)
        else $error("address trap dropped before accept");
endmodule // dsac_checker
`default_nettype wire

// *** dsac_pkg.sv ***
// Constants shared by the data-space access checker.
`default_nettype none
package dsac_pkg;
    // Address and data widths.
    localparam int DSAC_AW = 16;
    localparam int DSAC_DW = 16;
    // Implemented data memory: one window of words, upper half is Y space.
    localparam int DSAC_RAM_WORDS = 1024;
    localparam int DSAC_IDX_W = 10;
    localparam logic [15:0] DSAC_RAM_BASE = 16'h0800;
    localparam logic [15:0] DSAC_RAM_TOP = 16'h0FFF;
    localparam logic [15:0] DSAC_Y_BASE = 16'h0C00;
    localparam logic [15:0] DSAC_Y_TOP = 16'h0FFF;
    // Value returned for any refused or unimplemented fetch.
    localparam logic [15:0] DSAC_ZERO_WORD = 16'h0000;
    localparam logic [7:0] DSAC_ZERO_BYTE = 8'h00;
    // Near region reached by the short direct address field.
    localparam int DSAC_NEAR_BITS = 13;
    localparam logic [15:0] DSAC_NEAR_TOP = 16'h1FFF;
    // Pointer steps for byte and word operands.
    localparam logic [15:0] DSAC_BYTE_STEP = 16'h0001;
    localparam logic [15:0] DSAC_WORD_STEP = 16'h0002;
    // Stack pointer reset, lower stack bound and limit reset.
    localparam logic [15:0] DSAC_SP_RESET = 16'h0800;
    localparam logic [15:0] DSAC_SFR_BOUND = 16'h0800;
    localparam logic [15:0] DSAC_LIM_RESET = 16'hFFFE;
endpackage
`default_nettype wire

// *** dsac_byte_lane.sv ***
// One byte-wide lane of the data memory with one write and two read ports.
`timescale 1ns/10ps
`default_nettype none
module dsac_byte_lane (
    // Clock.
    input wire logic clk_sys,
    // Write port.
    input wire logic wrEn,
    input wire logic [dsac_pkg::DSAC_IDX_W-1:0] wrIdx,
    input wire logic [7:0] wrByte,
    // X read port.
    input wire logic [dsac_pkg::DSAC_IDX_W-1:0] rdIdxA,
    output logic [7:0] rdByteA,
    // Y read port.
    input wire logic [dsac_pkg::DSAC_IDX_W-1:0] rdIdxB,
    output logic [7:0] rdByteB
);
    import dsac_pkg::*;

    logic [7:0] mem [DSAC_RAM_WORDS];

    // Contents are not reset; software must initialise what it reads.
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrIdx] <= wrByte;
        end
    end

    // Reads are combinational; the caller registers the result.
    assign rdByteA = mem[rdIdxA];
    assign rdByteB = mem[rdIdxB];
endmodule // dsac_byte_lane
`default_nettype wire

// *** dsac_exc_model.sv ***
// Exception-logic model that accepts trap requests after a set delay.
`timescale 1ns/10ps
`default_nettype none
module dsac_exc_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Cycles a pending request waits before it is accepted.
    input wire logic [3:0] ackDelay,
    // Trap requests and accept pulses.
    input wire logic addrErrReq,
    input wire logic stackErrReq,
    output logic addrErrAck,
    output logic stackErrAck
);
    logic [3:0] addrCnt_q;
    logic [3:0] stackCnt_q;

    // Address trap: one accept pulse, then the count restarts so that a
    // request still seen in the accept cycle is not accepted twice.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addrCnt_q <= 4'h0;
            addrErrAck <= 1'b0;
        end else begin
            addrErrAck <= addrErrReq && !addrErrAck && addrCnt_q == ackDelay;
            addrCnt_q <= (addrErrReq && !addrErrAck && addrCnt_q != ackDelay)
                ? addrCnt_q + 4'h1 : 4'h0;
        end
    end

    // Stack trap: same slow or prompt acceptance.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stackCnt_q <= 4'h0;
            stackErrAck <= 1'b0;
        end else begin
            stackErrAck <= stackErrReq && !stackErrAck &&
                stackCnt_q == ackDelay;
            stackCnt_q <= (stackErrReq && !stackErrAck &&
                stackCnt_q != ackDelay) ? stackCnt_q + 4'h1 : 4'h0;
        end
    end
endmodule // dsac_exc_model
`default_nettype wire

// *** dsac_checker_tb.sv ***
// Self-checking testbench for the data-space access checker.
`timescale 1ns/10ps
`default_nettype none
module dsac_checker_tb;
    import dsac_pkg::*;
    logic clk_sys, rst_n, dualOperandMultiplyClass;
    logic xReqValid, xReqWrite, xReqByte, xReqViaXPtr, xRdValid_q;
    logic [15:0] xReqAddr, xWrData, xWregPrev, xRdData_q, xWregData_q;
    logic yReqValid, yRdValid_q, ptrInc, ptrDec, ptrByte, dirFullField;
    logic [15:0] yReqAddr, yRdData_q, ptrIn, ptrNext_q, dirField, dirAddr_q;
    logic stackPush, stackPop, pushIsCall, pushIsException, spWrite, limWrite;
    logic [15:0] pushData, spWrData, limWrData, stackPointerReg, stackLimitReg;
    logic [7:0] statusLowByte;
    logic addrErrAck, stackErrAck, addrErrReq, stackErrReq;
    logic [3:0] ackDelay;
    int bad_count = 0;
    int comparisons = 0;

    // Design and the exception-logic partner.
    dsac_checker dut (.clk_sys, .rst_n, .dualOperandMultiplyClass,
        .xReqValid, .xReqWrite, .xReqByte, .xReqViaXPtr, .xReqAddr, .xWrData,
        .xWregPrev, .xRdValid_q, .xRdData_q, .xWregData_q, .yReqValid,
        .yReqAddr, .yRdValid_q, .yRdData_q, .ptrIn, .ptrInc, .ptrDec,
        .ptrByte, .ptrNext_q, .dirField, .dirFullField, .dirAddr_q,
        .stackPush, .stackPop, .pushIsCall, .pushIsException, .pushData,
        .statusLowByte, .spWrite, .spWrData, .limWrite, .limWrData,
        .stackPointerReg, .stackLimitReg, .addrErrAck, .stackErrAck,
        .addrErrReq, .stackErrReq);
    dsac_exc_model exc (.clk_sys, .rst_n, .ackDelay, .addrErrReq,
        .stackErrReq, .addrErrAck, .stackErrAck);

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Inputs always change by the same small delay after the edge.
    task cyc;
        @(posedge clk_sys);
        #1;
    endtask

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bus cycles are held one edge, then one idle cycle follows.
    task xwr(input logic b, input logic [15:0] a, input logic [15:0] d);
        {xReqValid, xReqWrite, xReqByte, xReqAddr, xWrData} = {2'b11, b, a, d};
        cyc;
        xReqValid = 1'b0;
        cyc;
    endtask

    task xrd(input logic b, input logic [15:0] a, input logic [15:0] e);
        {xReqValid, xReqWrite, xReqByte, xReqAddr} = {2'b10, b, a};
        cyc;
        chk("xValid", xRdValid_q, 1'b1);
        chk("xData", xRdData_q, e);
        xReqValid = 1'b0;
        cyc;
    endtask

    task yrd(input logic [15:0] a, input logic [15:0] e);
        {yReqValid, yReqAddr} = {1'b1, a};
        cyc;
        chk("yValid", yRdValid_q, 1'b1);
        chk("yData", yRdData_q, e);
        yReqValid = 1'b0;
        cyc;
    endtask

    task push(input logic [15:0] d, input logic c, x, err);
        {stackPush, pushData, pushIsCall, pushIsException} = {1'b1, d, c, x};
        cyc;
        chk("stackTrap", stackErrReq, err);
        stackPush = 1'b0;
        cyc;
    endtask

    task pop(input logic [15:0] e);
        stackPop = 1'b1;
        cyc;
        chk("popValid", xRdValid_q, 1'b1);
        chk("popData", xRdData_q, e);
        stackPop = 1'b0;
        cyc;
    endtask

    // Bounded wait for the partner to accept a trap request.
    task await_clr(input logic s);
        int n;
        for (n = 0; n < 20 && (s ? stackErrReq : addrErrReq) !== 1'b0; n++)
            cyc;
        if (n == 20) begin
            bad_count++;
            report_and_stop;
        end
    endtask

    task t_reset;
        chk("spReset", stackPointerReg, DSAC_SP_RESET);
        chk("limBit0", {15'h0000, stackLimitReg[0]}, 16'h0000);
        chk("trapIdle", {14'h0000, addrErrReq, stackErrReq}, 16'h0000);
        $display("test reset done");
    endtask

    task t_memory;
        xwr(1'b0, 16'h0800, 16'hA55A);
        xwr(1'b0, 16'h0802, 16'h1234);
        xwr(1'b1, 16'h0803, 16'h00C3);
        xrd(1'b0, 16'h0802, 16'hC334);
        xWregPrev = 16'h7E00;
        xrd(1'b1, 16'h0801, 16'h00A5);
        chk("wregMerge", xWregData_q, 16'h7EA5);
        xrd(1'b1, 16'h0800, 16'h005A);
        xrd(1'b0, 16'h0400, DSAC_ZERO_WORD);
        xrd(1'b0, 16'hFFFE, DSAC_ZERO_WORD);
        $display("test memory done");
    endtask

    task t_spaces;
        xwr(1'b0, 16'h0C02, 16'h6789);
        xReqViaXPtr = 1'b1;
        xrd(1'b0, 16'h0C02, 16'h6789);
        dualOperandMultiplyClass = 1'b1;
        xrd(1'b0, 16'h0C02, DSAC_ZERO_WORD);
        yrd(16'h0C02, 16'h6789);
        yrd(16'h0802, DSAC_ZERO_WORD);
        dualOperandMultiplyClass = 1'b0;
        $display("test spaces done");
    endtask

    task t_misalign;
        ackDelay = 4'h3;
        xrd(1'b0, 16'h0801, 16'hA55A);
        chk("addrTrap", addrErrReq, 1'b1);
        cyc;
        chk("addrHeld", addrErrReq, 1'b1);
        await_clr(1'b0);
        xwr(1'b0, 16'h0803, 16'hFFFF);
        chk("addrTrapWr", addrErrReq, 1'b1);
        await_clr(1'b0);
        ackDelay = 4'h0;
        xrd(1'b0, 16'h0802, 16'hC334);
        xrd(1'b1, 16'h0803, 16'h00C3);
        chk("byteNoTrap", addrErrReq, 1'b0);
        $display("test misalign done");
    endtask

    task t_pointer;
        int i;
        logic [15:0] st;
        ptrIn = 16'h1000;
        for (i = 0; i < 4; i++) begin
            {ptrInc, ptrDec, ptrByte} = {!i[1], i[1], !i[0]};
            st = i[0] ? DSAC_WORD_STEP : DSAC_BYTE_STEP;
            st = i[1] ? 16'h1000 - st : 16'h1000 + st;
            cyc;
            chk("ptrNext", ptrNext_q, st);
        end
        {ptrInc, ptrDec, dirField, dirFullField} = {2'b00, 16'hF234, 1'b0};
        cyc;
        chk("dirShort", dirAddr_q, 16'h1234);
        dirFullField = 1'b1;
        cyc;
        chk("dirFull", dirAddr_q, 16'hF234);
        $display("test pointer done");
    endtask

    task t_stack;
        ackDelay = 4'h2;
        {limWrite, limWrData, spWrite, spWrData} = {1'b1, 16'h0803, 1'b1,
            16'h0800};
        cyc;
        {limWrite, spWrite} = 2'b00;
        cyc;
        chk("limit", stackLimitReg, 16'h0802);
        statusLowByte = 8'h5A;
        push(16'hBEEF, 1'b1, 1'b0, 1'b0);
        push(16'h1234, 1'b0, 1'b1, 1'b0);
        push(16'h7777, 1'b0, 1'b0, 1'b1);
        chk("spPush", stackPointerReg, 16'h0806);
        await_clr(1'b1);
        pop(16'h7777);
        pop(16'h5A34);
        pop(16'h00EF);
        pop(DSAC_ZERO_WORD);
        chk("underflow", stackErrReq, 1'b1);
        chk("spPop", stackPointerReg, 16'h07FE);
        await_clr(1'b1);
        $display("test stack done");
    endtask

    // Watchdog against a hung run.
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        report_and_stop;
    end

    // Main sequence: all inputs quiet, reset for ten cycles, then tests.
    initial begin
        {dualOperandMultiplyClass, xReqValid, xReqWrite, xReqByte} = 4'h0;
        {xReqViaXPtr, xReqAddr, xWrData, xWregPrev} = 49'h0;
        {yReqValid, yReqAddr, ptrIn, ptrInc, ptrDec, ptrByte} = 36'h0;
        {dirField, dirFullField, stackPush, stackPop, pushIsCall} = 20'h0;
        {pushIsException, pushData, statusLowByte, spWrite} = 26'h0;
        {spWrData, limWrite, limWrData, ackDelay} = 37'h0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset;
        t_memory;
        t_spaces;
        t_misalign;
        t_pointer;
        t_stack;
        report_and_stop;
    end
endmodule // dsac_checker_tb
`default_nettype wire
